/* inc/host_port_regs.vh */
// Constants for the host-side parallel port controller
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH
// Bus widths
`define HP_ADDR_W 13
`define HP_DATA_W 8
// Sequencer states
`define HP_ST_IDLE 3'h0
`define HP_ST_SETUP 3'h1
`define HP_ST_STROBE 3'h2
`define HP_ST_HOLD 3'h3
`define HP_ST_DONE 3'h4
// Phase times in ns and derived cycle counts at 4 ns per cycle
`define HP_CLK_PERIOD_NS 4
`define HP_SETUP_NS 20
`define HP_STROBE_NS 100
`define HP_HOLD_NS 20
`define HP_SETUP_CYC ((`HP_SETUP_NS + `HP_CLK_PERIOD_NS - 1) / `HP_CLK_PERIOD_NS)
`define HP_STROBE_CYC ((`HP_STROBE_NS + `HP_CLK_PERIOD_NS - 1) / `HP_CLK_PERIOD_NS)
`define HP_HOLD_CYC ((`HP_HOLD_NS + `HP_CLK_PERIOD_NS - 1) / `HP_CLK_PERIOD_NS)
// Reset values
`define HP_ADDR_RST 13'h0000
`define HP_DATA_RST 8'h00
`endif

/* rtl/pin_sync.v */
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input wire sys_clk,
    input wire reset_n,
    input wire pin_in,
    output reg level_out
);
    reg meta_reg; // First stage, read only by second stage
    reg s2_reg; // Second stage
    reg s3_reg; // Third stage

    // Shift chain; output follows only when stages two and three agree
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            level_out <= 1'b1;
        end else begin
            meta_reg <= pin_in;
            s2_reg <= meta_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_out <= s3_reg;
            end
        end
    end
endmodule // pin_sync
`default_nettype wire

/* rtl/host_parallel_bus_port.v */
// Host controller driving the device's asynchronous 8-bit parallel port
`timescale 1ns/1ps
`default_nettype none
`include "host_port_regs.vh"
// How it works
// - Drive 13-bit address, MSB bit 12.
// - Data over 8-bit bidirectional bus.
// - Hold address, data, select through strobe rise.
// - Style input high: data strobe plus direction.
// - Device reset output returns device to reset.
module host_parallel_bus_port (
    input wire sys_clk,
    input wire reset_n,
    input wire req_valid,
    output wire req_ready,
    input wire req_write,
    input wire [12:0] req_addr,
    input wire [7:0] req_wdata,
    output reg rsp_valid,
    output reg [7:0] rsp_rdata,
    input wire style_data_strobe,
    input wire device_reset_req,
    output reg [12:0] address_out,
    input wire [7:0] host_data_in,
    output reg [7:0] host_data_out,
    output reg host_data_oe,
    output reg chip_select_n,
    output reg read_strobe_n,
    output reg write_strobe_n,
    output reg bus_style_select,
    input wire irq_out_n,
    output wire irq_pending,
    output reg device_reset_n
);
    reg [2:0] state_reg; // Sequencer state
    reg [2:0] state_next;
    reg [5:0] count_reg; // Phase cycle counter
    reg [5:0] count_next;
    reg write_reg; // Current access is a write
    wire irq_level; // Synchronised interrupt pin, driven by the filter instance
    reg [7:0] data_meta_reg; // Data bus first stage, read only by the second
    reg [7:0] data_s2_reg; // Data bus second stage
    reg [7:0] data_s3_reg; // Data bus third stage
    reg [7:0] data_level_reg; // Filtered data bus level
    // Phase reloads kept at full width, low bits taken where they are used
    localparam [31:0] SETUP_LEN = `HP_SETUP_CYC - 1;
    localparam [31:0] STROBE_LEN = `HP_STROBE_CYC - 1;
    localparam [31:0] HOLD_LEN = `HP_HOLD_CYC - 1;

    // Interrupt pin comes from outside, so it is filtered
    pin_sync u_irq_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin_in(irq_out_n),
        .level_out(irq_level)
    );

    // Level stays asserted while any unmasked source in the device is active
    assign irq_pending = ~irq_level;

    // Accept a new request only when idle
    assign req_ready = (state_reg == `HP_ST_IDLE);

    // Phase length for the phase being entered
    function [5:0] phase_len;
        input [2:0] st;
        begin
            case (st)
                `HP_ST_SETUP: phase_len = SETUP_LEN[5:0];
                `HP_ST_STROBE: phase_len = STROBE_LEN[5:0];
                `HP_ST_HOLD: phase_len = HOLD_LEN[5:0];
                default: phase_len = 6'h00;
            endcase
        end
    endfunction

    // Style selection helper; high means data strobe plus direction
    function bus_style_select_in_use;
        input sel;
        begin
            bus_style_select_in_use = sel;
        end
    endfunction

    // Next state: idle, setup, strobe, hold, done
    always @* begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            `HP_ST_IDLE: begin
                if (req_valid) begin
                    state_next = `HP_ST_SETUP;
                    count_next = phase_len(`HP_ST_SETUP);
                end
            end
            `HP_ST_SETUP: begin
                if (count_reg == 6'h00) begin
                    state_next = `HP_ST_STROBE;
                    count_next = phase_len(`HP_ST_STROBE);
                end else begin
                    count_next = count_reg - 6'h01;
                end
            end
            `HP_ST_STROBE: begin
                if (count_reg == 6'h00) begin
                    state_next = `HP_ST_HOLD;
                    count_next = phase_len(`HP_ST_HOLD);
                end else begin
                    count_next = count_reg - 6'h01;
                end
            end
            `HP_ST_HOLD: begin
                if (count_reg == 6'h00) begin
                    state_next = `HP_ST_DONE;
                end else begin
                    count_next = count_reg - 6'h01;
                end
            end
            `HP_ST_DONE: begin
                state_next = `HP_ST_IDLE;
            end
            default: begin
                state_next = `HP_ST_IDLE;
                count_next = 6'h00;
            end
        endcase
    end

    // Data bus is an outside pin: three flops, taken once stages two and three agree.
    // The strobe stays low for many cycles, so the added lag still lands inside it.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_meta_reg <= `HP_DATA_RST;
            data_s2_reg <= `HP_DATA_RST;
            data_s3_reg <= `HP_DATA_RST;
            data_level_reg <= `HP_DATA_RST;
        end else begin
            data_meta_reg <= host_data_in;
            data_s2_reg <= data_meta_reg;
            data_s3_reg <= data_s2_reg;
            // A word still settling is held off until two stages match
            if (data_s2_reg == data_s3_reg) begin
                data_level_reg <= data_s3_reg;
            end
        end
    end

    // Sequencer and pin registers
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= `HP_ST_IDLE;
            count_reg <= 6'h00;
            write_reg <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= `HP_DATA_RST;
            address_out <= `HP_ADDR_RST;
            host_data_out <= `HP_DATA_RST;
            host_data_oe <= 1'b0;
            chip_select_n <= 1'b1;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            bus_style_select <= 1'b0;
            device_reset_n <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            rsp_valid <= 1'b0;
            // Device reset follows the user request one cycle later; callers wait for idle first
            device_reset_n <= ~device_reset_req;
            case (state_reg)
                `HP_ST_IDLE: begin
                    // Style may only change between accesses
                    bus_style_select <= style_data_strobe;
                    if (req_valid) begin
                        write_reg <= req_write;
                        address_out <= req_addr;
                        host_data_out <= req_wdata;
                        host_data_oe <= req_write;
                        chip_select_n <= 1'b0;
                        // Second pin: write strobe, or direction line
                        if (bus_style_select_in_use(style_data_strobe)) begin
                            write_strobe_n <= ~req_write;
                        end else begin
                            write_strobe_n <= 1'b1;
                        end
                    end
                end
                `HP_ST_SETUP: begin
                    if (count_reg == 6'h00) begin
                        // Strobes only inside an asserted select
                        if (bus_style_select) begin
                            read_strobe_n <= 1'b0;
                        end else if (write_reg) begin
                            write_strobe_n <= 1'b0;
                        end else begin
                            read_strobe_n <= 1'b0;
                        end
                    end
                end
                `HP_ST_STROBE: begin
                    if (count_reg == 6'h00) begin
                        // Filtered level, settled well inside the strobe
                        if (!write_reg) begin
                            rsp_rdata <= data_level_reg;
                        end
                        read_strobe_n <= 1'b1;
                        if (!bus_style_select) begin
                            write_strobe_n <= 1'b1;
                        end
                    end
                end
                `HP_ST_HOLD: begin
                    // Keep address, data and select through the rising edge
                    if (count_reg == 6'h00) begin
                        chip_select_n <= 1'b1;
                        host_data_oe <= 1'b0;
                        write_strobe_n <= 1'b1;
                    end
                end
                `HP_ST_DONE: begin
                    rsp_valid <= 1'b1;
                end
                default: begin
                    chip_select_n <= 1'b1;
                end
            endcase
        end
    end
endmodule // host_parallel_bus_port
`default_nettype wire

/* sim/access_checker.sv */
// Assertion checker for the host parallel port controller
`timescale 1ns/1ps
`default_nettype none
module access_checker (
    input wire sys_clk,
    input wire reset_n,
    input wire req_valid,
    input wire req_ready,
    input wire rsp_valid,
    input wire device_reset_req,
    input wire [12:0] address_out,
    input wire [7:0] host_data_out,
    input wire host_data_oe,
    input wire chip_select_n,
    input wire read_strobe_n,
    input wire write_strobe_n,
    input wire bus_style_select,
    input wire irq_out_n,
    input wire irq_pending,
    input wire device_reset_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Direction line may sit low idle in data-strobe style
    a_strobe_qual: assert property (chip_select_n |-> read_strobe_n && (bus_style_select || write_strobe_n))
        else $error("strobe outside select");
    a_no_contend: assert property (!chip_select_n && !read_strobe_n && (!bus_style_select || write_strobe_n)
        |-> !host_data_oe) else $error("host drives during read");
    // Data and address held through the latching edge
    a_wdata_hold: assert property ((bus_style_select ? ($rose(read_strobe_n) && !write_strobe_n)
        : $rose(write_strobe_n)) |-> host_data_oe && !chip_select_n && $stable(host_data_out) && $stable(address_out))
        else $error("write data not held");
    a_addr_hold: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable(address_out))
        else $error("address moved in access");
    a_style_hold: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable(bus_style_select))
        else $error("style moved in access");
    // Fixed access length, one pulse of completion
    a_resp_time: assert property (req_valid && req_ready |-> ##[30:40] rsp_valid)
        else $error("no completion");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("completion too long");
    a_irq_set: assert property (!irq_out_n [*7] |-> irq_pending)
        else $error("interrupt missed");
    a_irq_clr: assert property (irq_out_n [*7] |-> !irq_pending)
        else $error("interrupt stuck");
    a_dev_reset: assert property (device_reset_req |=> !device_reset_n)
        else $error("device reset not driven");
    c_read: cover property (!chip_select_n && !read_strobe_n && write_strobe_n);
    c_write: cover property ($rose(write_strobe_n) && !bus_style_select);
    c_irq: cover property (irq_pending);
endmodule // access_checker
bind host_parallel_bus_port access_checker u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .device_reset_req(device_reset_req), .address_out(address_out), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .bus_style_select(bus_style_select), .irq_out_n(irq_out_n),
    .irq_pending(irq_pending), .device_reset_n(device_reset_n)
);
`default_nettype wire

/* sim/dev_model.sv */
// Behavioural model of the register device behind the port
`timescale 1ns/1ps
`default_nettype none
module dev_model (
    input wire logic device_reset_n,
    input wire logic bus_style_select,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [12:0] address_out,
    input wire logic [7:0] host_data_in,
    input wire logic [3:0] irq_event,
    input wire logic [3:0] irq_mask,
    output logic [7:0] dev_data,
    output logic irq_out_n
);
    logic [7:0] mem [0:8191]; // Full 13-bit register space
    logic [7:0] last_reg = 8'h00; // Last value driven
    logic rd_en; // Qualified read
    assign rd_en = device_reset_n && !chip_select_n && !read_strobe_n && (!bus_style_select || write_strobe_n);
    // Released bus shows inverse of last value so stale samples fail
    assign dev_data = rd_en ? mem[address_out] : ~last_reg;
    always @(negedge rd_en) last_reg = mem[address_out];
    // Separate-strobe write latches at strobe rise
    always @(posedge write_strobe_n) if (device_reset_n && !chip_select_n && !bus_style_select) mem[address_out] = host_data_in;
    // Data-strobe write, direction low
    always @(posedge read_strobe_n) if (device_reset_n && !chip_select_n && bus_style_select && !write_strobe_n) mem[address_out] = host_data_in;
    always @(negedge device_reset_n) for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
    // Each of four levels has its own mask
    assign irq_out_n = !(|(irq_event & ~irq_mask));
endmodule // dev_model
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the host parallel port controller
`timescale 1ns/1ps
`default_nettype none
`include "host_port_regs.vh"
module tb_top;
    logic sys_clk = 0, reset_n = 0, req_valid = 0, req_ready, req_write = 0, rsp_valid, style_data_strobe = 0;
    logic device_reset_req = 0, host_data_oe, chip_select_n, read_strobe_n, write_strobe_n, bus_style_select;
    logic irq_out_n, irq_pending, device_reset_n;
    logic [12:0] req_addr = 13'h0000, address_out;
    logic [7:0] req_wdata = 8'h00, rsp_rdata, host_data_in, host_data_out, dev_data, q;
    logic [3:0] irq_event = 4'h0, irq_mask = 4'h0;
    int n_mismatch = 0, num_checks = 0;
    // Wire resolution: host wins only while enabled
    assign host_data_in = host_data_oe ? host_data_out : dev_data;
    host_parallel_bus_port dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .style_data_strobe(style_data_strobe), .device_reset_req(device_reset_req), .address_out(address_out),
        .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .bus_style_select(bus_style_select), .irq_out_n(irq_out_n), .irq_pending(irq_pending),
        .device_reset_n(device_reset_n)
    );
    dev_model m (
        .device_reset_n(device_reset_n), .bus_style_select(bus_style_select), .chip_select_n(chip_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .address_out(address_out),
        .host_data_in(host_data_in), .irq_event(irq_event), .irq_mask(irq_mask), .dev_data(dev_data),
        .irq_out_n(irq_out_n)
    );
    initial forever #2 sys_clk = ~sys_clk;
    task chk8(input string s, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin n_mismatch++; $display("unexpected %s exp %h got %h", s, e, g); end
    endtask
    task chk1(input string s, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin n_mismatch++; $display("unexpected %s exp %b got %b", s, e, g); end
    endtask
    // One access, bounded wait for completion
    task acc(input logic s, input logic w, input logic [12:0] a, input logic [7:0] d);
        int n;
        @(negedge sys_clk);
        style_data_strobe = s; req_write = w; req_addr = a; req_wdata = d; req_valid = 1;
        @(negedge sys_clk);
        req_valid = 0;
        chk1("req_ready_busy", 1'b0, req_ready);
        n = 0;
        while (rsp_valid !== 1'b1 && n < 60) begin @(posedge sys_clk); #1; n++; end
        chk1("rsp_valid", 1'b1, rsp_valid);
        chk1("req_ready_idle", 1'b1, req_ready);
        chk8("access_cycles", 8'(`HP_SETUP_CYC + `HP_STROBE_CYC + `HP_HOLD_CYC + 1), n[7:0]);
        q = rsp_rdata;
    endtask
    task t_sep;
        acc(0, 1, 13'h1fff, 8'ha5);
        acc(0, 1, 13'h0000, 8'h3c);
        chk8("mem_top", 8'ha5, m.mem[13'h1fff]);
        acc(0, 0, 13'h1fff, 8'h00);
        chk8("rd_top", 8'ha5, q);
        acc(0, 0, 13'h0000, 8'h00);
        chk8("rd_bot", 8'h3c, q);
        $display("test separate strobes done");
    endtask
    task t_ds;
        acc(1, 1, 13'h0aaa, 8'h5a);
        chk8("mem_ds", 8'h5a, m.mem[13'h0aaa]);
        acc(1, 0, 13'h0aaa, 8'h00);
        chk8("rd_ds", 8'h5a, q);
        acc(1, 0, 13'h1fff, 8'h00);
        chk8("rd_cross", 8'ha5, q);
        $display("test data strobe done");
    endtask
    // Each mask level blocks, then passes, then clears
    task t_irq;
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk); irq_event = 4'h1 << i; irq_mask = 4'h1 << i;
            repeat (8) @(negedge sys_clk);
            chk1("irq_masked", 1'b0, irq_pending);
            irq_mask = 4'h0;
            repeat (8) @(negedge sys_clk);
            chk1("irq_set", 1'b1, irq_pending);
            irq_event = 4'h0;
            repeat (8) @(negedge sys_clk);
            chk1("irq_clear", 1'b0, irq_pending);
        end
        $display("test interrupt done");
    endtask
    task t_rst;
        @(negedge sys_clk); device_reset_req = 1;
        repeat (2) @(negedge sys_clk);
        chk1("device_reset_n", 1'b0, device_reset_n);
        device_reset_req = 0;
        repeat (2) @(negedge sys_clk);
        acc(0, 0, 13'h1fff, 8'h00);
        chk8("rd_after_rst", 8'h00, q);
        $display("test device reset done");
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles needed
    initial begin
        #100000;
        n_mismatch++;
        final_report;
    end
    initial begin
        repeat (16) @(negedge sys_clk);
        reset_n = 1;
        t_sep;
        t_ds;
        t_irq;
        t_rst;
        final_report;
    end
endmodule // tb_top
`default_nettype wire
